// *** bench/adc_front_end_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module adc_front_end_model
  (
    // Control from the sequencer
    input  wire logic       i_clock,
    input  wire logic [4:0] i_channel,
    input  wire logic       i_sample_hold,
    // Held sample
    output logic      [9:0] o_code,
    output logic            o_over
  );

  // The code is taken only while sampling, so a channel change later in
  // the conversion cannot leak into the result. Channel 0x1F stands for
  // an input above the reference.
  always_ff @(posedge i_clock)
  begin
    if (i_sample_hold)
    begin
      o_code <= {i_channel, 5'h0A};
      o_over <= (i_channel == 5'h1F);
    end
  end

endmodule // adc_front_end_model

`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_map.svh"

module tb;
  logic       clk, rst_n, wr, rd, ev, pd;
  logic       over, hold, ev_out, irq_r, irq_w, tsens, cap;
  logic [1:0] reference_select;
  logic [4:0] addr, chan;
  logic [7:0] wdata, rdata, d, h;
  logic [9:0] code;
  int         fail_count, n_checks, t0;
  int         cyc = 0;
  int         ev_cnt = 0;

  adc_conversion_sequencer DUT (
    .I_CLOCK(clk), .I_RESETN(rst_n), .I_CE(1'b1),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_SAR_CODE(code), .I_SAR_OVER(over),
    .O_CHANNEL(chan), .O_REFERENCE(reference_select), .O_CAP_REDUCED(cap),
    .O_TEMP_SENSOR_ON(tsens), .O_SAMPLE_HOLD(hold),
    .I_EVENT(ev), .I_STANDBY(1'b0), .I_POWERDOWN(pd),
    .O_RESULT_EVENT(ev_out), .O_CLOCK_REQUEST(),
    .O_IRQ_RESULT_READY_FLAG(irq_r), .O_IRQ_WINDOW(irq_w));

  adc_front_end_model FE (
    .i_clock(clk), .i_channel(chan), .i_sample_hold(hold),
    .o_code(code), .o_over(over));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Conversions are tens of cycles; a hung sequencer ends the run here.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ev_out === 1'b1)
      ev_cnt <= ev_cnt + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ****************************************************************
  // Bus and comparison helpers
  // ****************************************************************
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_res(input logic [15:0] exp);
    rd_reg(`ADC_OFS_RESULT_HI);
    h = d;
    rd_reg(`ADC_OFS_RESULT_LO);
    check({h, d}, exp);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (ev_out !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(ev_out, 1'b1);
    @(posedge clk);
    #1 check(ev_out, 1'b0);
  endtask

  task automatic conv(input logic [4:0] c);
    wr_reg(`ADC_OFS_CHSEL, {3'h0, c});
    wr_reg(`ADC_OFS_COMMAND, 8'h01);
    wait_done();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_reg(`ADC_OFS_CTRLA);
    check(d, 8'h00);
    wr_reg(5'h07, 8'hFF);
    rd_reg(5'h07);
    check(d, 8'h00);
  endtask

  task automatic t_single();
    wr_reg(`ADC_OFS_CTRLA, 8'h01);
    wr_reg(`ADC_OFS_INTEN, 8'h01);
    wr_reg(`ADC_OFS_CHSEL, 8'h03);
    repeat (3) @(posedge clk);
    check(chan, 5'h03);
    wr_reg(`ADC_OFS_COMMAND, 8'h01);
    repeat (4) @(posedge clk);
    wr_reg(`ADC_OFS_CHSEL, 8'h09);
    rd_reg(`ADC_OFS_COMMAND);
    check(d, 8'h01);
    check(chan, 5'h03);
    wait_done();
    rd_reg(`ADC_OFS_COMMAND);
    check(d, 8'h00);
    rd_reg(`ADC_OFS_INTFLAG);
    check(d, 8'h01);
    check(irq_r, 1'b1);
    rd_res(16'h006A);
    rd_reg(`ADC_OFS_INTFLAG);
    check(d, 8'h00);
    check(irq_r, 1'b0);
    check(chan, 5'h09);
  endtask

  task automatic t_sat_temp();
    conv(5'h1F);
    wr_reg(`ADC_OFS_INTFLAG, 8'h01);
    rd_reg(`ADC_OFS_INTFLAG);
    check(d, 8'h00);
    rd_res(16'h03FF);
    wr_reg(`ADC_OFS_CHSEL, 8'h1E);
    repeat (3) @(posedge clk);
    check(tsens, 1'b1);
    wr_reg(`ADC_OFS_CTRLC, 8'h40);
    wr_reg(`ADC_OFS_CTRLD, 8'h10);
    wr_reg(`ADC_OFS_SAMPCTRL, 8'h04);
    wr_reg(`ADC_OFS_CTRLA, 8'h00);
    wr_reg(`ADC_OFS_CTRLA, 8'h01);
    wr_reg(`ADC_OFS_COMMAND, 8'h01);
    t0 = ev_cnt;
    repeat (50) @(posedge clk);
    check(16'(ev_cnt - t0), 16'd0);
    check(cap, 1'b1);
    check(reference_select, 2'h0);
    wait_done();
    rd_res(16'h03CA);
    wr_reg(`ADC_OFS_CTRLC, 8'h00);
    wr_reg(`ADC_OFS_CTRLD, 8'h00);
    wr_reg(`ADC_OFS_SAMPCTRL, 8'h00);
    wr_reg(`ADC_OFS_CHSEL, 8'h03);
    repeat (3) @(posedge clk);
    check(tsens, 1'b0);
  endtask

  task automatic t_window();
    logic [9:0] lo [3] = '{10'h080, 10'h050, 10'h050};
    logic [9:0] hi [3] = '{10'h0F0, 10'h060, 10'h080};
    logic       e;
    for (int s = 0; s < 3; s++)
      for (int m = 0; m < 5; m++)
      begin
        wr_reg(`ADC_OFS_WINLO_LO, lo[s][7:0]);
        wr_reg(`ADC_OFS_WINHI_LO, hi[s][7:0]);
        wr_reg(`ADC_OFS_CTRLE, 8'(m));
        conv(5'h03);
        case (m)
          1: e = 10'h06A < lo[s];
          2: e = 10'h06A > hi[s];
          3: e = 10'h06A > lo[s] && 10'h06A < hi[s];
          4: e = 10'h06A < lo[s] || 10'h06A > hi[s];
          default: e = 1'b0;
        endcase
        rd_reg(`ADC_OFS_INTFLAG);
        check(d[1], e);
        check(irq_w, 1'b0);
        wr_reg(`ADC_OFS_INTFLAG, 8'h03);
      end
    wr_reg(`ADC_OFS_CTRLE, 8'h00);
  endtask

  task automatic t_event();
    wr_reg(`ADC_OFS_EVCTRL, 8'h01);
    ev <= 1'b1;
    repeat (4) @(posedge clk);
    ev <= 1'b0;
    rd_reg(`ADC_OFS_COMMAND);
    check(d, 8'h01);
    wait_done();
    rd_reg(`ADC_OFS_COMMAND);
    check(d, 8'h00);
    wr_reg(`ADC_OFS_EVCTRL, 8'h00);
  endtask

  task automatic t_free();
    wr_reg(`ADC_OFS_CTRLA, 8'h03);
    conv(5'h03);
    t0 = cyc;
    wr_reg(`ADC_OFS_CHSEL, 8'h05);
    wait_done();
    check(16'(cyc - t0), 16'd26);
    rd_res(16'h006A);
    rd_reg(`ADC_OFS_COMMAND);
    check(d, 8'h01);
    wait_done();
    rd_res(16'h00AA);
    wr_reg(`ADC_OFS_CTRLA, 8'h01);
    wait_done();
    t0 = ev_cnt;
    repeat (60) @(posedge clk);
    check(16'(ev_cnt - t0), 16'd0);
    wr_reg(`ADC_OFS_CTRLB, 8'h01);
    conv(5'h03);
    rd_res(16'h00D4);
    wr_reg(`ADC_OFS_CTRLB, 8'h00);
  endtask

  task automatic t_pdown();
    wr_reg(`ADC_OFS_COMMAND, 8'h01);
    repeat (8) @(posedge clk);
    pd <= 1'b1;
    t0 = ev_cnt;
    repeat (100) @(posedge clk);
    check(16'(ev_cnt - t0), 16'd0);
    pd <= 1'b0;
    wait_done();
    rd_reg(`ADC_OFS_STATUS);
    check(d[0], 1'b1);
  endtask

  initial
  begin
    rst_n = 1'b0;
    {wr, rd, ev, pd, addr, wdata} = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_sat_temp();
    t_window();
    t_event();
    t_free();
    t_pdown();
    stop_test();
  end

endmodule // tb

`default_nettype wire

// *** rtl/adc_conversion_sequencer.sv ***
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_map.svh"

module adc_conversion_sequencer
  #(
    parameter int unsigned PRESC_W = 8
  )
  (
    // Clock, reset, enable
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    input  wire logic        I_CE,
    // Register port
    input  wire logic [4:0]  I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [7:0]  O_RDATA,
    // Analog front end
    input  wire logic [9:0]  I_SAR_CODE,
    input  wire logic        I_SAR_OVER,
    output logic      [4:0]  O_CHANNEL,
    output logic      [1:0]  O_REFERENCE,
    output logic             O_CAP_REDUCED,
    output logic             O_TEMP_SENSOR_ON,
    output logic             O_SAMPLE_HOLD,
    // Events and power
    input  wire logic        I_EVENT,
    input  wire logic        I_STANDBY,
    input  wire logic        I_POWERDOWN,
    output logic             O_RESULT_EVENT,
    output logic             O_CLOCK_REQUEST,
    output logic             O_IRQ_RESULT_READY_FLAG,
    output logic             O_IRQ_WINDOW
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]  ctrla_q, ctrlb_q, ctrlc_q, ctrld_q, ctrle_q, sampctrl_q;
  logic [4:0]  chsel_q;
  logic        evstart_en_q;
  logic [1:0]  inten_q, intflag_q;
  logic        start_q;
  logic [15:0] result_q, winlo_q, winhi_q, acc_q;
  logic        result_invalid_q;
  logic [4:0]  act_chan_q;
  logic [1:0]  act_ref_q;
  logic [PRESC_W-1:0] presc_q, presc_top;
  logic        evt_s1_q, evt_s2_q, evt_s3_q;
  logic        sb_s1_q, sb_s2_q, pd_s1_q, pd_s2_q;
  logic        first_q;
  logic        halted_q;
  logic [6:0]  nsamp_q;
  logic [5:0]  cnt_q;
  adc_seq_pkg::seq_state_e state_q;

  logic wr_ev, rd_res, evt_rise, adc_tick, running, last_tick, done;
  logic [6:0] samp_total;
  logic [15:0] final_val;
  logic [9:0] code;
  logic win_hit;

  // ****************************************************************
  // Synchronisers and decode
  // ****************************************************************
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      evt_s1_q <= 1'b0;
      evt_s2_q <= 1'b0;
      evt_s3_q <= 1'b0;
      sb_s1_q  <= 1'b0;
      sb_s2_q  <= 1'b0;
      pd_s1_q  <= 1'b0;
      pd_s2_q  <= 1'b0;
    end
    else if (I_CE)
    begin
      evt_s1_q <= I_EVENT;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
      sb_s1_q  <= I_STANDBY;
      sb_s2_q  <= sb_s1_q;
      pd_s1_q  <= I_POWERDOWN;
      pd_s2_q  <= pd_s1_q;
    end
  end

  // The module is frozen in standby without run-in-standby, and always
  // in power-down, so a conversion waits there and resumes; one that saw
  // power-down sets STATUS bit 0 (result invalid) when it completes.
  logic enabled, active;
  assign enabled = ctrla_q[`ADC_CTRLA_ENABLE];
  assign active  = enabled && !pd_s2_q &&
                   (!sb_s2_q || ctrla_q[`ADC_CTRLA_RUNSTBY]);
  assign wr_ev    = I_WR && (I_ADDR == `ADC_OFS_COMMAND) && I_WDATA[0];
  assign evt_rise = evt_s2_q && !evt_s3_q && evstart_en_q;
  assign rd_res   = I_RD && (I_ADDR == `ADC_OFS_RESULT_LO ||
                             I_ADDR == `ADC_OFS_RESULT_HI);
  assign running  = (state_q != adc_seq_pkg::ST_IDLE);

  // Prescaler held at zero outside conversions to fix the start latency.
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      presc_q <= '0;
    else if (I_CE)
    begin
      if (!enabled || !(running || start_q))
        presc_q <= '0;
      else if (active)
        presc_q <= (presc_q == presc_top) ? '0 : presc_q + PRESC_W'(1);
    end
  end
  // Computed nine bits wide so that the largest divider does not wrap.
  assign presc_top = PRESC_W'((9'h001 << ({1'b0, ctrlc_q[2:0]} + 4'h1)) -
                              9'h001);
  assign adc_tick  = active && (presc_q == presc_top);

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      ctrla_q      <= `ADC_RESET_BYTE;
      ctrlb_q      <= `ADC_RESET_BYTE;
      ctrlc_q      <= `ADC_RESET_BYTE;
      ctrld_q      <= `ADC_RESET_BYTE;
      ctrle_q      <= `ADC_RESET_BYTE;
      sampctrl_q   <= `ADC_RESET_BYTE;
      chsel_q      <= 5'h00;
      evstart_en_q <= 1'b0;
      inten_q      <= 2'h0;
      winlo_q      <= 16'h0000;
      winhi_q      <= 16'h0000;
    end
    else if (I_CE && I_WR)
    begin
      unique case (I_ADDR)
        `ADC_OFS_CTRLA:    ctrla_q    <= I_WDATA & 8'h83;
        `ADC_OFS_CTRLB:    ctrlb_q    <= I_WDATA & 8'h07;
        `ADC_OFS_CTRLC:    ctrlc_q    <= I_WDATA & 8'h77;
        `ADC_OFS_CTRLD:    ctrld_q    <= I_WDATA & 8'h7F;
        `ADC_OFS_CTRLE:    ctrle_q    <= I_WDATA & 8'h07;
        `ADC_OFS_SAMPCTRL: sampctrl_q <= I_WDATA & 8'h1F;
        `ADC_OFS_CHSEL:    chsel_q    <= I_WDATA[4:0];
        `ADC_OFS_EVCTRL:   evstart_en_q <= I_WDATA[0];
        `ADC_OFS_INTEN:    inten_q    <= I_WDATA[1:0];
        `ADC_OFS_WINLO_LO: winlo_q[7:0]  <= I_WDATA;
        `ADC_OFS_WINLO_HI: winlo_q[15:8] <= I_WDATA;
        `ADC_OFS_WINHI_LO: winhi_q[7:0]  <= I_WDATA;
        `ADC_OFS_WINHI_HI: winhi_q[15:8] <= I_WDATA;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  // Reserved accumulation code 7 falls back to a single sample.
  assign samp_total = (ctrlb_q[2:0] == 3'h7) ? 7'd1
                      : 7'(7'd1 << ctrlb_q[2:0]);
  assign last_tick  = adc_tick && (state_q == adc_seq_pkg::ST_CONVERT) &&
                      (cnt_q == 6'(`ADC_CONV_CYCLES - `ADC_SH_CYCLE - 1));
  assign done       = last_tick && (nsamp_q == samp_total - 7'd1);
  assign code       = I_SAR_OVER ? `ADC_FULL_SCALE : I_SAR_CODE;
  assign final_val  = acc_q + {6'h00, code};

  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state_q <= adc_seq_pkg::ST_IDLE;
      cnt_q   <= 6'h00;
      nsamp_q <= 7'h00;
      first_q <= 1'b1;
    end
    else if (I_CE)
    begin
      if (!enabled)
      begin
        state_q <= adc_seq_pkg::ST_IDLE;
        first_q <= 1'b1;
      end
      else if (adc_tick)
      begin
        unique case (state_q)
          adc_seq_pkg::ST_IDLE:
            if (start_q)
            begin
              cnt_q   <= 6'h00;
              nsamp_q <= 7'h00;
              first_q <= 1'b0;
              state_q <= (first_q && ctrld_q[6:4] != 3'h0)
                         ? adc_seq_pkg::ST_INIT
                         : adc_seq_pkg::ST_DELAY;
            end
          adc_seq_pkg::ST_INIT:
            if (cnt_q == {ctrld_q[6:4], 3'h7})
            begin
              cnt_q   <= 6'h00;
              first_q <= 1'b0;
              state_q <= adc_seq_pkg::ST_DELAY;
            end
            else
              cnt_q <= cnt_q + 6'h01;
          adc_seq_pkg::ST_DELAY:
            if (cnt_q >= {2'h0, ctrld_q[3:0]})
            begin
              cnt_q   <= 6'h00;
              state_q <= adc_seq_pkg::ST_SAMPLE;
            end
            else
              cnt_q <= cnt_q + 6'h01;
          adc_seq_pkg::ST_SAMPLE:
            if (cnt_q >= {1'b0, sampctrl_q[4:0]})
            begin
              cnt_q   <= 6'h00;
              state_q <= adc_seq_pkg::ST_CONVERT;
            end
            else
              cnt_q <= cnt_q + 6'h01;
          // Delay and sample phases take the first two of the 13 ticks.
          adc_seq_pkg::ST_CONVERT:
            if (cnt_q == 6'(`ADC_CONV_CYCLES - `ADC_SH_CYCLE - 1))
            begin
              cnt_q <= 6'h00;
              if (!done)
              begin
                nsamp_q <= nsamp_q + 7'd1;
                state_q <= adc_seq_pkg::ST_DELAY;
              end
              else if (ctrla_q[`ADC_CTRLA_FREERUN] && start_q)
              begin
                nsamp_q <= 7'h00;
                state_q <= adc_seq_pkg::ST_DELAY;
              end
              else
                state_q <= adc_seq_pkg::ST_IDLE;
            end
            else
              cnt_q <= cnt_q + 6'h01;
          default:
            state_q <= adc_seq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Start bit: set by software or event, cleared when single run ends.
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      start_q <= 1'b0;
    else if (I_CE)
    begin
      if (!enabled)
        start_q <= 1'b0;
      else if (wr_ev || evt_rise)
        start_q <= 1'b1;
      else if (done && !ctrla_q[`ADC_CTRLA_FREERUN])
        start_q <= 1'b0;
    end
  end

  // Active selection follows the shadows while idle and during the last conversion tick.
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      act_chan_q <= 5'h00;
      act_ref_q  <= `ADC_REF_INTERNAL;
    end
    else if (I_CE && (!running || (state_q == adc_seq_pkg::ST_CONVERT &&
             cnt_q == 6'(`ADC_CONV_CYCLES - `ADC_SH_CYCLE - 1))))
    begin
      act_chan_q <= chsel_q;
      act_ref_q  <= ctrlc_q[5:4];
    end
  end

  // ****************************************************************
  // Accumulator, result and flags
  // ****************************************************************
  adc_win_cmp u_win
  (
    .i_value (final_val),
    .i_low   (winlo_q),
    .i_high  (winhi_q),
    .i_mode  (ctrle_q[2:0]),
    .o_match (win_hit)
  );

  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      acc_q            <= 16'h0000;
      result_q         <= 16'h0000;
      result_invalid_q <= 1'b0;
      halted_q         <= 1'b0;
    end
    else if (I_CE)
    begin
      if (pd_s2_q && running)
        halted_q <= 1'b1;
      if (state_q == adc_seq_pkg::ST_IDLE)
        acc_q <= 16'h0000;
      else if (last_tick)
        acc_q <= done ? 16'h0000 : final_val;
      if (done)
      begin
        result_q         <= final_val;
        result_invalid_q <= halted_q;
        halted_q         <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      intflag_q <= 2'h0;
    else if (I_CE)
    begin
      // A new event beats a clear in the same cycle.
      if (done)
        intflag_q[`ADC_INT_RESULT_READY_FLAG] <= 1'b1;
      else if (rd_res || (I_WR && I_ADDR == `ADC_OFS_INTFLAG &&
               I_WDATA[`ADC_INT_RESULT_READY_FLAG]))
        intflag_q[`ADC_INT_RESULT_READY_FLAG] <= 1'b0;
      if (done && win_hit)
        intflag_q[`ADC_INT_WINDOW] <= 1'b1;
      else if (I_WR && I_ADDR == `ADC_OFS_INTFLAG &&
               I_WDATA[`ADC_INT_WINDOW])
        intflag_q[`ADC_INT_WINDOW] <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_RDATA          <= 8'h00;
      O_RESULT_EVENT   <= 1'b0;
      O_IRQ_RESULT_READY_FLAG     <= 1'b0;
      O_IRQ_WINDOW     <= 1'b0;
      O_CLOCK_REQUEST  <= 1'b0;
      O_SAMPLE_HOLD    <= 1'b0;
      O_CHANNEL        <= 5'h00;
      O_REFERENCE      <= 2'h0;
      O_CAP_REDUCED    <= 1'b0;
      O_TEMP_SENSOR_ON <= 1'b0;
    end
    else if (I_CE)
    begin
      O_RESULT_EVENT   <= done && enabled;
      O_IRQ_RESULT_READY_FLAG     <= intflag_q[0] && inten_q[0];
      O_IRQ_WINDOW     <= intflag_q[1] && inten_q[1];
      O_CLOCK_REQUEST  <= sb_s2_q && (running || start_q);
      O_SAMPLE_HOLD    <= state_q == adc_seq_pkg::ST_SAMPLE;
      O_CHANNEL        <= act_chan_q;
      O_REFERENCE      <= act_ref_q;
      O_CAP_REDUCED    <= ctrlc_q[`ADC_CTRLC_CAP];
      O_TEMP_SENSOR_ON <= act_chan_q == `ADC_TEMP_CHANNEL;
      O_RDATA          <= 8'h00;
      if (I_RD)
      begin
        unique case (I_ADDR)
          `ADC_OFS_CTRLA:     O_RDATA <= ctrla_q;
          `ADC_OFS_CTRLB:     O_RDATA <= ctrlb_q;
          `ADC_OFS_CTRLC:     O_RDATA <= ctrlc_q;
          `ADC_OFS_CTRLD:     O_RDATA <= ctrld_q;
          `ADC_OFS_CTRLE:     O_RDATA <= ctrle_q;
          `ADC_OFS_SAMPCTRL:  O_RDATA <= sampctrl_q;
          `ADC_OFS_CHSEL:     O_RDATA <= {3'h0, chsel_q};
          `ADC_OFS_COMMAND:   O_RDATA <= {7'h00, start_q};
          `ADC_OFS_EVCTRL:    O_RDATA <= {7'h00, evstart_en_q};
          `ADC_OFS_INTEN:     O_RDATA <= {6'h00, inten_q};
          `ADC_OFS_INTFLAG:   O_RDATA <= {6'h00, intflag_q};
          `ADC_OFS_RESULT_LO: O_RDATA <= result_q[7:0];
          `ADC_OFS_RESULT_HI: O_RDATA <= result_q[15:8];
          `ADC_OFS_WINLO_LO:  O_RDATA <= winlo_q[7:0];
          `ADC_OFS_WINLO_HI:  O_RDATA <= winlo_q[15:8];
          `ADC_OFS_WINHI_LO:  O_RDATA <= winhi_q[7:0];
          `ADC_OFS_WINHI_HI:  O_RDATA <= winhi_q[15:8];
          `ADC_OFS_STATUS:    O_RDATA <= {7'h00, result_invalid_q};
          default:            O_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_START_SET: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_CE && enabled && wr_ev |=> start_q)
    else $error("start bit not set by command");
  AST_SINGLE_CLR: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_CE && done && !ctrla_q[1] && !wr_ev && !evt_rise |=> !start_q)
    else $error("start bit not cleared after single run");
  AST_READY_SET: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_CE && done |=> intflag_q[0])
    else $error("ready flag not set");
  AST_EVENT_PULSE: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    O_RESULT_EVENT |=> !O_RESULT_EVENT)
    else $error("ready event longer than one cycle");
  AST_FREERUN: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_CE && done && ctrla_q[1] && start_q
    |=> state_q == adc_seq_pkg::ST_DELAY)
    else $error("free run did not restart");
  AST_LOCK: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_CE && state_q == adc_seq_pkg::ST_SAMPLE && $past(I_CE) &&
    $past(state_q) == adc_seq_pkg::ST_SAMPLE
    |-> $stable(act_chan_q))
    else $error("channel changed while sampling");
  AST_SAT: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_SAR_OVER |-> code == `ADC_FULL_SCALE)
    else $error("no saturation");
  AST_WIN_OFF: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_CE && ctrle_q[2:0] == 3'h0 && !intflag_q[1] |=> !intflag_q[1])
    else $error("window flag set while off");
  AST_IRQ: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_CE && intflag_q[0] && inten_q[0] |=> O_IRQ_RESULT_READY_FLAG)
    else $error("irq not raised");
  COV_SINGLE: cover property (@(posedge I_CLOCK) done && !ctrla_q[1]);
  COV_FREE: cover property (@(posedge I_CLOCK) done && ctrla_q[1]);
  COV_WIN: cover property (@(posedge I_CLOCK) done && win_hit);
  COV_EVT: cover property (@(posedge I_CLOCK) evt_rise);

endmodule // adc_conversion_sequencer

`default_nettype wire

// *** rtl/adc_seq_map.svh ***
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADC_OFS_CTRLA      5'h00
`define ADC_OFS_CTRLB      5'h01
`define ADC_OFS_CTRLC      5'h02
`define ADC_OFS_CTRLD      5'h03
`define ADC_OFS_CTRLE      5'h04
`define ADC_OFS_SAMPCTRL   5'h05
`define ADC_OFS_CHSEL      5'h06
`define ADC_OFS_COMMAND    5'h08
`define ADC_OFS_EVCTRL     5'h09
`define ADC_OFS_INTEN      5'h0A
`define ADC_OFS_INTFLAG    5'h0B
`define ADC_OFS_RESULT_LO  5'h10
`define ADC_OFS_RESULT_HI  5'h11
`define ADC_OFS_WINLO_LO   5'h12
`define ADC_OFS_WINLO_HI   5'h13
`define ADC_OFS_WINHI_LO   5'h14
`define ADC_OFS_WINHI_HI   5'h15
`define ADC_OFS_STATUS     5'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define ADC_CTRLA_ENABLE   0
`define ADC_CTRLA_FREERUN  1
`define ADC_CTRLA_RUNSTBY  7
`define ADC_CTRLC_CAP      6
`define ADC_INT_RESULT_READY_FLAG     0
`define ADC_INT_WINDOW     1

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define ADC_RESET_BYTE     8'h00
`define ADC_CONV_CYCLES    13
`define ADC_SH_CYCLE       2
`define ADC_FULL_SCALE     10'h3FF
`define ADC_TEMP_CHANNEL   5'h1E
`define ADC_REF_INTERNAL   2'h0

`endif

// *** rtl/adc_seq_pkg.sv ***
package adc_seq_pkg;

  typedef enum logic [2:0] {
    WIN_OFF     = 3'h0,
    WIN_BELOW   = 3'h1,
    WIN_ABOVE   = 3'h2,
    WIN_INSIDE  = 3'h3,
    WIN_OUTSIDE = 3'h4
  } win_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INIT,
    ST_DELAY,
    ST_SAMPLE,
    ST_CONVERT
  } seq_state_e;

endpackage

// *** rtl/adc_win_cmp.sv ***
`timescale 1ns/10ps
`default_nettype none

module adc_win_cmp
  (
    // Comparison inputs
    input  wire logic [15:0] i_value,
    input  wire logic [15:0] i_low,
    input  wire logic [15:0] i_high,
    input  wire logic [2:0]  i_mode,
    // Result
    output logic             o_match
  );

  always_comb
  begin
    unique case (i_mode)
      adc_seq_pkg::WIN_BELOW:   o_match = i_value < i_low;
      adc_seq_pkg::WIN_ABOVE:   o_match = i_value > i_high;
      adc_seq_pkg::WIN_INSIDE:  o_match = (i_value > i_low) &&
                                          (i_value < i_high);
      adc_seq_pkg::WIN_OUTSIDE: o_match = (i_value < i_low) ||
                                          (i_value > i_high);
      default:                  o_match = 1'b0;
    endcase
  end

endmodule // adc_win_cmp

`default_nettype wire
